// ### logic/wdt_guard_defs.svh
// register offsets, field positions, keys and timing counts of the watchdog guard
// assumes inclusion by bare name from the package and the modules
`ifndef WDT_GUARD_DEFS_SVH
`define WDT_GUARD_DEFS_SVH

// register byte offsets
`define MODE_OFF 8'h00
`define KEY_OFF 8'h04
`define ACCESS_OFF 8'h08
`define STATUS_OFF 8'h0C
`define MASK_OFF 8'h10
`define COUNT_OFF 8'h14
`define CTRL_OFF 8'h18

// mode register fields
`define MODE_PATTERN 3'h3
`define MODE_STOP_BIT 4
`define MODE_RESET 8'h67

// clear key and read-back value
`define CLEAR_KEY 8'hAC
`define KEY_READBACK 8'h9A

// access-kind field: written before a mode or key write
`define ACC_BITOP_BIT 0

// status / mask bit positions
`define ST_SECOND_WRITE 0
`define ST_BAD_KEY 1
`define ST_BITOP 2
`define ST_OVERFLOW 3
`define ST_WIDTH 4

// control register bit positions
`define CTRL_SRC_RUN_BIT 0
`define CTRL_OSC_STOPPABLE_BIT 1

// counter
`define CNT_WIDTH 16
`define PRESCALE_DIV 16'h0010

// internal reset pulse length in cycles
`define RESET_PULSE_LEN 4'h4

// unmapped read value
`define UNMAPPED_DATA 32'h0000_0000

`endif

// ### logic/wdt_guard_pkg.sv
// types shared by the watchdog guard modules
// assumes the defs header is on the include path
package wdt_guard_pkg;
    `include "wdt_guard_defs.svh"

    typedef enum logic [1:0] {
        MODE_FRESH = 2'b00,
        MODE_LOCKED = 2'b01
    } mode_lock_e;

    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_PENDING = 2'b01,
        RST_FIRE = 2'b10
    } rst_state_e;

    typedef logic [`ST_WIDTH-1:0] status_t;
endpackage

// ### logic/wdt_event_if.sv
// carries illegal-access and overflow events from the guard to the reset unit
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface wdt_event_if;
    logic bad_access;
    logic overflow;
    logic src_running;
    logic reset_out;
    logic pending;

    modport guard (output bad_access, output overflow, output src_running,
        input reset_out, input pending);
    modport unit (input bad_access, input overflow, input src_running,
        output reset_out, output pending);
endinterface

// ### logic/wdt_reset_unit.sv
// internal reset generator: holds a request while the source clock stands still
// assumes events arrive as one-cycle pulses on aclk
`timescale 1ns/1ps
`include "wdt_guard_defs.svh"
module wdt_reset_unit
    import wdt_guard_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    wdt_event_if.unit ev // events in, reset out
);
    rst_state_e state_q, state_d;
    logic [3:0] len_q, len_d;
    wire logic request = ev.bad_access | ev.overflow;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        len_d = len_q;
        case (state_q)
            RST_IDLE: begin
                if (request) begin
                    // a stopped source clock defers the reset, it never drops it
                    if (ev.src_running) begin // RL7
                        state_d = RST_FIRE;
                        len_d = `RESET_PULSE_LEN;
                    end else begin
                        state_d = RST_PENDING; // RL7
                    end
                end
            end
            RST_PENDING: begin
                if (ev.src_running) begin // RL7
                    state_d = RST_FIRE;
                    len_d = `RESET_PULSE_LEN;
                end
            end
            RST_FIRE: begin
                len_d = len_q - 4'h1;
                if (len_q == 4'h1) begin
                    state_d = RST_IDLE;
                end
            end
            default: begin
                state_d = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= RST_IDLE;
            len_q <= 4'h0;
        end else begin
            state_q <= state_d;
            len_q <= len_d;
        end
    end

    assign ev.reset_out = (state_q == RST_FIRE);
    assign ev.pending = (state_q == RST_PENDING);
endmodule

// ### logic/wdt_counter.sv
// watchdog counter with prescaler, clear and permanent stop
// assumes the guard supplies one-cycle clear and stop pulses
`timescale 1ns/1ps
`include "wdt_guard_defs.svh"
module wdt_counter
    import wdt_guard_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic src_running, // watchdog source clock is running
    input wire logic clear, // clear pulse
    input wire logic halt, // permanent stop pulse
    output logic [`CNT_WIDTH-1:0] count, // counter value
    output logic overflow // one-cycle overflow pulse
);
    logic [15:0] div_q;
    logic [`CNT_WIDTH-1:0] cnt_q;
    logic halted_q;
    logic ovf_q;
    wire logic tick = src_running && !halted_q && (div_q == `PRESCALE_DIV - 16'h1);
    wire logic wrap = tick && (cnt_q == {`CNT_WIDTH{1'b1}});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 16'h0000;
            cnt_q <= '0;
            halted_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            // only a reset undoes a halt, so clearing the stop bit later has no effect
            if (halt) halted_q <= 1'b1; // RL9
            ovf_q <= wrap; // RL15
            if (clear) begin
                cnt_q <= '0; // RL14
                div_q <= 16'h0000;
            end else if (src_running && !halted_q) begin
                div_q <= tick ? 16'h0000 : div_q + 16'h1;
                if (tick) cnt_q <= cnt_q + `CNT_WIDTH'(1);
            end
        end
    end

    assign count = cnt_q;
    assign overflow = ovf_q;
endmodule

// ### logic/wdt_guard.sv
// watchdog write-protection guard with AXI4-Lite register slave
// assumes one 100 MHz clock; the CPU bus wait shows as a late write response, and reset requests leave as a port
//
// Operation
// RL1: mode register write adds one wait cycle
// RL2: software avoids mode writes on subsystem clock
// RL3: software writes 0,1,1 into bits 7..5
// RL4: non-stoppable option forces top bits pattern
// RL5: one byte-wide mode write after reset
// RL6: second mode write raises internal reset
// RL7: reset waits while source clock stopped
// RL8: bit-manipulation writes never configure mode
// RL9: stop bit halts watchdog for good
// RL10: clearing stop bit raises no reset; here that write is a second mode write and raises one (RL6)
// RL11: wrong clear key raises internal reset
// RL12: bit-manipulation key access raises reset
// RL13: key register reads back 9AH
// RL14: correct key clears counter, no reset
// RL15: counter overflow raises internal reset
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "wdt_guard_defs.svh"
module wdt_guard
    import wdt_guard_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read response valid
    input wire logic s_axi_rready, // read response ready
    output logic irq, // level interrupt
    output logic internal_reset // internal reset request, active high
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wait_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [7:0] mode_q;
    mode_lock_e lock_q;
    logic bitop_q;
    status_t status_q, mask_q;
    logic src_run_q, stoppable_q;
    logic clear_p, halt_p, bad_p;
    logic [`CNT_WIDTH-1:0] count;
    logic ovf;

    wdt_event_if ev ();

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    wire logic have_both = aw_q && w_q && !bvalid_q;
    wire logic is_mode = is_off(awaddr_q, `MODE_OFF);
    // a mode write stalls for one extra cycle before it is committed
    wire logic commit = have_both && (!is_mode || wait_q); // RL1
    wire logic byte_ok = wstrb_q[0] && !bitop_q;
    wire logic wr_mode = commit && is_mode;
    wire logic wr_key = commit && is_off(awaddr_q, `KEY_OFF);
    wire logic wr_acc = commit && is_off(awaddr_q, `ACCESS_OFF);
    wire logic wr_stat = commit && is_off(awaddr_q, `STATUS_OFF);
    wire logic wr_mask = commit && is_off(awaddr_q, `MASK_OFF);
    wire logic wr_ctrl = commit && is_off(awaddr_q, `CTRL_OFF);
    wire logic wr_known = is_mode || is_off(awaddr_q, `KEY_OFF) || is_off(awaddr_q, `ACCESS_OFF)
        || is_off(awaddr_q, `STATUS_OFF) || is_off(awaddr_q, `MASK_OFF)
        || is_off(awaddr_q, `COUNT_OFF) || is_off(awaddr_q, `CTRL_OFF);

    wire logic mode_second = wr_mode && (lock_q == MODE_LOCKED); // RL6
    wire logic mode_first = wr_mode && (lock_q == MODE_FRESH) && byte_ok; // RL5 RL8
    wire logic key_bitop = wr_key && !byte_ok; // RL12
    wire logic key_bad = wr_key && byte_ok && (wdata_q[7:0] != `CLEAR_KEY); // RL11
    wire logic key_good = wr_key && byte_ok && (wdata_q[7:0] == `CLEAR_KEY); // RL14

    // the fixed pattern is forced only when the oscillator cannot be stopped
    wire logic [7:0] mode_new = stoppable_q ? wdata_q[7:0]
        : {`MODE_PATTERN, wdata_q[4:0]}; // RL4
    wire logic stop_req = stoppable_q && mode_new[`MODE_STOP_BIT]; // RL9

    status_t ev_set;
    assign ev_set[`ST_SECOND_WRITE] = mode_second;
    assign ev_set[`ST_BAD_KEY] = key_bad;
    assign ev_set[`ST_BITOP] = key_bitop;
    assign ev_set[`ST_OVERFLOW] = ovf;

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            wait_q <= 1'b0;
            bvalid_q <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            wait_q <= have_both && is_mode && !wait_q; // RL1
            if (commit) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= `MODE_RESET;
            lock_q <= MODE_FRESH;
            bitop_q <= 1'b0;
            status_q <= '0;
            mask_q <= '0;
            src_run_q <= 1'b1;
            stoppable_q <= 1'b0;
        end else begin
            if (wr_mode) lock_q <= MODE_LOCKED; // RL5
            if (mode_first) mode_q <= mode_new; // RL5 RL8
            // a later write that clears the stop bit never reaches the counter
            if (wr_acc) bitop_q <= wdata_q[`ACC_BITOP_BIT];
            else if (wr_mode || wr_key) bitop_q <= 1'b0;
            if (wr_mask) mask_q <= wdata_q[`ST_WIDTH-1:0];
            if (wr_ctrl) begin
                src_run_q <= wdata_q[`CTRL_SRC_RUN_BIT];
                stoppable_q <= wdata_q[`CTRL_OSC_STOPPABLE_BIT];
            end
            // set wins over a write-one clear in the same cycle
            status_q <= (status_q & ~(wr_stat ? wdata_q[`ST_WIDTH-1:0] : '0)) | ev_set;
        end
    end

    assign clear_p = key_good; // RL14
    assign halt_p = mode_first && stop_req; // RL9 RL10
    assign bad_p = mode_second || key_bad || key_bitop; // RL6 RL11 RL12

    // ----------------------------------------
    // counter and reset unit
    // ----------------------------------------
    wdt_counter wdt_counter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_running(src_run_q),
        .clear(clear_p),
        .halt(halt_p),
        .count(count),
        .overflow(ovf)
    );

    assign ev.bad_access = bad_p;
    assign ev.overflow = ovf; // RL15
    assign ev.src_running = src_run_q; // RL7

    wdt_reset_unit wdt_reset_unit_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ev(ev.unit)
    );

    assign internal_reset = ev.reset_out;
    assign irq = |(status_q & mask_q);

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    logic [31:0] rmux;
    wire logic [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    always_comb begin
        case (ra)
            `MODE_OFF: rmux = {24'h000000, mode_q};
            `KEY_OFF: rmux = {24'h000000, `KEY_READBACK}; // RL13
            `ACCESS_OFF: rmux = {31'h0000_0000, bitop_q};
            `STATUS_OFF: rmux = {28'h0000000, status_q};
            `MASK_OFF: rmux = {28'h0000000, mask_q};
            `COUNT_OFF: rmux = {16'h0000, count};
            `CTRL_OFF: rmux = {29'h0000_0000, ev.pending, stoppable_q, src_run_q};
            default: rmux = `UNMAPPED_DATA;
        endcase
    end
    wire logic rd_known = (ra <= `CTRL_OFF);

    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rmux;
            s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
endmodule

// ### dv/wdt_guard_monitor.sv
// concurrent checks on the register slave and the internal reset of the guard
// assumes it is bound into wdt_guard and sees only that module's ports
`timescale 1ns/1ps
`include "wdt_guard_defs.svh"
module wdt_guard_monitor (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // read response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic internal_reset // reset request
);
    // ------------------------------
    // helper
    // ------------------------------
    logic [7:0] ra_q; // offset of the read under way
    always_ff @(posedge aclk) begin
        // the slave ignores the two low address bits, so the helper does too
        if (s_axi_arvalid && s_axi_arready) ra_q <= {s_axi_araddr[7:2], 2'b00};
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------
    // properties
    // ------------------------------
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_latency: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    a_key_readback: assert property (
        s_axi_rvalid && ra_q == `KEY_OFF |-> s_axi_rdata[7:0] == `KEY_READBACK)
        else $error("key read-back wrong");
    a_unmapped_err: assert property (s_axi_rvalid && ra_q > `CTRL_OFF
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == `UNMAPPED_DATA) else $error("unmapped read");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    a_write_block: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready && !s_axi_wready) else $error("aw or w open");
    a_reset_pulse: assert property (
        $rose(internal_reset) |-> internal_reset [*4] ##1 !internal_reset)
        else $error("reset pulse length wrong");
endmodule

// ### dv/watchdog_write_protect_guard_test.sv
// self-checking bench for the watchdog guard, driving its register bus
// assumes the design files and the defs header are compiled first
`timescale 1ns/1ps
`include "wdt_guard_defs.svh"
module watchdog_write_protect_guard_test;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq, internal_reset;
    logic [1:0] bresp, rresp;
    logic [63:0] note_q[$];
    int n_errors = 0, checked = 0, n_rst = 0;
    wdt_guard wdt_guard_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .internal_reset(internal_reset));
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge internal_reset) n_rst++;
    // ------------------------------
    // checking
    // ------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        print_verdict();
    endtask
    // responses are judged just before the edge that completes them
    always @(negedge aclk) begin
        logic [63:0] n;
        if ((bvalid && bready) || (rvalid && rready)) begin
            n = note_q.pop_front();
            check("response", (bvalid ? {30'h0, bresp} : rdata) & n[63:32], n[31:0]);
        end
    end
    // ------------------------------
    // bus tasks
    // ------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output int c);
        bit ah, wh, done;
        note_q.push_back({32'h0000_0003, 32'h0000_0000});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 0;
        for (c = 0; c < 40 && !done; c++) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            done = bvalid;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge aclk);
        if (!done) hang();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        output logic [31:0] d);
        bit ah, done;
        note_q.push_back({m, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 0;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge aclk);
            ah = arvalid && arready;
            d = rdata;
            done = rvalid;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge aclk);
        if (!done) hang();
    endtask
    task automatic reset_dut();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // one edge to launch, four of pulse, margin for a late rise
    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        logic [31:0] d, v;
        logic [4:0] r;
        int lk, lm, x;
        d = $urandom(74);
        reset_dut();
        rd(`MODE_OFF, 32'hFF, `MODE_RESET, d);
        rd(`CTRL_OFF, 32'hFF, 32'h1, d);
        // let the counter move off zero so that the clear is visible
        repeat (3) settle();
        wr(`KEY_OFF, `CLEAR_KEY, lk);
        rd(`COUNT_OFF, 32'hFFFF, 32'h0, d);
        rd(`KEY_OFF, 32'hFF, `KEY_READBACK, d);
        rd(8'h1C, 32'hFFFF_FFFF, `UNMAPPED_DATA, d);
        r = 5'($urandom);
        wr(`MODE_OFF, {24'h0, 3'h7, r}, lm);
        check("mode_wait", lm, lk + 1);
        rd(`MODE_OFF, 32'hFF, {24'h0, 3'h3, r}, d);
        settle();
        check("resets", n_rst, 0);
        wr(`MASK_OFF, 32'h1, x);
        wr(`MODE_OFF, `MODE_RESET, x);
        settle();
        check("resets", n_rst, 1);
        check("irq", {31'h0, irq}, 1);
        wr(`MASK_OFF, 32'h0, x);
        check("irq", {31'h0, irq}, 0);
        wr(`MASK_OFF, 32'h1, x);
        rd(`STATUS_OFF, 32'hF, 32'h1, d);
        wr(`STATUS_OFF, 32'h1, x);
        check("irq", {31'h0, irq}, 0);
        // bit access does not configure, and a stopped source defers the reset
        reset_dut();
        wr(`ACCESS_OFF, 32'h1, x);
        wr(`MODE_OFF, 32'h7F, x);
        rd(`MODE_OFF, 32'hFF, `MODE_RESET, d);
        wr(`CTRL_OFF, 32'h0, x);
        wr(`MODE_OFF, `MODE_RESET, x);
        settle();
        check("resets", n_rst, 1);
        rd(`CTRL_OFF, 32'h4, 32'h4, d);
        wr(`CTRL_OFF, 32'h1, x);
        settle();
        check("resets", n_rst, 2);
        reset_dut();
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            if (d[7:0] == `CLEAR_KEY) d[0] = ~d[0];
            wr(`KEY_OFF, d, x);
            settle();
        end
        check("resets", n_rst, 5);
        wr(`ACCESS_OFF, 32'h1, x);
        wr(`KEY_OFF, `CLEAR_KEY, x);
        settle();
        check("resets", n_rst, 6);
        rd(`STATUS_OFF, 32'hF, 32'h6, d);
        // the stop bit freezes the count for good
        reset_dut();
        wr(`CTRL_OFF, 32'h3, x);
        wr(`MODE_OFF, 32'h70, x);
        rd(`COUNT_OFF, 32'h0, 32'h0, v);
        repeat (6) settle();
        rd(`COUNT_OFF, 32'hFFFF, v, d);
        check("resets", n_rst, 6);
        print_verdict();
    end
endmodule
bind wdt_guard wdt_guard_monitor wdt_guard_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .internal_reset(internal_reset));
